// ==== hw/sscu_pkg.sv ====
/*
  Constants, types and register map of the socket send command unit.
  Assumes one 200 MHz clock, an AXI4-Lite master on the register side and a
  protocol engine on the same clock on the link side.
*/
package sscu_pkg;

  // ----------------------------------------
  // Register byte offsets
  // ----------------------------------------
  localparam logic [7:0] REG_MODE = 8'h00;
  localparam logic [7:0] REG_CMD = 8'h04;
  localparam logic [7:0] REG_TX_WR = 8'h08;
  localparam logic [7:0] REG_TX_RD = 8'h0C;
  localparam logic [7:0] REG_MSS = 8'h10;
  localparam logic [7:0] REG_FREE = 8'h14;
  localparam logic [7:0] REG_STATE = 8'h18;
  localparam logic [7:0] REG_EV_STATUS = 8'h1C;
  localparam logic [7:0] REG_EV_CLEAR = 8'h20;
  localparam logic [7:0] REG_EV_ENABLE = 8'h24;
  localparam logic [7:0] REG_PEER_LO = 8'h28;
  localparam logic [7:0] REG_PEER_HI = 8'h2C;

  // ----------------------------------------
  // Codes, reset values and responses
  // ----------------------------------------
  localparam logic [7:0] CMD_SEND = 8'h20;
  localparam logic [7:0] CMD_SEND_NO_RESOLVE = 8'h21;
  localparam logic [7:0] CMD_KEEPALIVE = 8'h22;
  localparam logic [2:0] MODE_CLOSED = 3'h0;
  localparam logic [2:0] MODE_TCP = 3'h1;
  localparam logic [2:0] MODE_UDP = 3'h2;
  localparam logic [2:0] MODE_RAW_IP = 3'h3;
  localparam logic [2:0] MODE_RAW_FRAME = 3'h4;
  localparam logic [7:0] CLOSED_STATE = 8'h00;
  localparam logic [7:0] OPEN_STATE = 8'h01;
  localparam logic [15:0] TX_BUF_BYTES = 16'h0800;
  localparam logic [15:0] MSS_RESET = 16'h05B4;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam int unsigned EV_W = 2;
  localparam int unsigned EV_DONE = 0;
  localparam int unsigned EV_TIMEOUT = 1;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ISSUE = 3'b001,
    ST_WAIT_SENT = 3'b010,
    ST_WAIT_ACK = 3'b011,
    ST_DONE = 3'b100,
    ST_CREDIT = 3'b101
  } sscu_fsm_type;

  typedef struct packed {
    logic [15:0] addr;
    logic [15:0] len;
    logic no_resolve;
    logic keepalive;
  } sscu_seg_type;

  typedef struct packed {
    logic sent;
    logic acked;
    logic timeout;
  } sscu_eng_evt_type;

endpackage

// ==== hw/sscu_seg_calc.sv ====
/*
  Length of the next segment to hand to the protocol engine.
  Assumes the mode and segment size come from registers on the same clock.
*/
`timescale 1ns/1ps
module sscu_seg_calc (
  // Socket setup
  input wire logic [2:0] mode,
  input wire logic [15:0] mss,
  // Bytes still to send
  input wire logic [15:0] remaining,
  // Next segment length
  output logic [15:0] seg_len
);

  logic segmented;

  // Only stream and datagram modes are cut; raw data goes out as it stands
  always_comb begin
    segmented = (mode == sscu_pkg::MODE_TCP) || (mode == sscu_pkg::MODE_UDP);
    if (segmented && (mss != 16'h0000) && (remaining > mss)) begin
      seg_len = mss;
    end else begin
      seg_len = remaining;
    end
  end

endmodule

// ==== hw/sscu_events.sv ====
/*
  Sticky event status, enable mask and level interrupt.
  Assumes set pulses and register writes come from logic on the same clock.
*/
`timescale 1ns/1ps
module sscu_events (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Event sources
  input wire logic [sscu_pkg::EV_W-1:0] ev_set,
  // Software access
  input wire logic clr_we,
  input wire logic en_we,
  input wire logic [sscu_pkg::EV_W-1:0] wr_data,
  // State
  output logic [sscu_pkg::EV_W-1:0] status,
  output logic [sscu_pkg::EV_W-1:0] enable,
  output logic irq
);

  logic [sscu_pkg::EV_W-1:0] status_d;
  logic [sscu_pkg::EV_W-1:0] enable_d;
  logic irq_d;

  // A set in the clearing cycle wins over the clear
  always_comb begin
    for (int i = 0; i < sscu_pkg::EV_W; i++) begin
      status_d[i] = ev_set[i] | (status[i] & ~(clr_we & wr_data[i]));
    end
    enable_d = en_we ? wr_data : enable;
    irq_d = |(status_d & enable_d);
  end

  // Registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status <= '0;
      enable <= '0;
      irq <= 1'b0;
    end else begin
      status <= status_d;
      enable <= enable_d;
      irq <= irq_d;
    end
  end

endmodule

// ==== hw/sscu_top.sv ====
/*
  Socket send command unit: AXI4-Lite registers, command decode, segmenting
  sequencer toward the protocol engine, free space accounting and events.
  Assumes the protocol engine runs on aclk and answers with one-cycle pulses.
*/
// The register addresses and the AXI4-Lite slave port were chosen for this implementation.
`timescale 1ns/1ps
module sscu_top (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address and data
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Protocol engine
  output logic eng_req,
  output sscu_pkg::sscu_seg_type eng_seg,
  output logic [47:0] peer_hw_address,
  input wire logic eng_ready,
  input wire sscu_pkg::sscu_eng_evt_type eng_evt,
  // Interrupt
  output logic irq
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  logic aw_have_q, aw_have_d, w_have_q, w_have_d;
  logic [7:0] aw_addr_q, aw_addr_d;
  logic [31:0] w_data_q, w_data_d;
  logic [3:0] w_strb_q, w_strb_d;
  logic awready_q, awready_d, wready_q, wready_d;
  logic bvalid_q, bvalid_d, arready_q, arready_d, rvalid_q, rvalid_d;
  logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
  logic [31:0] rdata_q, rdata_d;
  logic [2:0] mode_q, mode_d;
  logic [7:0] socket_state_q, socket_state_d;
  logic [15:0] tx_wr_q, tx_wr_d, tx_rd_q, tx_rd_d, mss_q, mss_d;
  logic [15:0] tx_free_space_q, tx_free_space_d;
  logic [15:0] remaining_q, remaining_d, total_q, total_d;
  logic [47:0] peer_q, peer_d;
  logic keep_q, keep_d, no_res_q, no_res_d;
  logic eng_req_q, eng_req_d;
  sscu_pkg::sscu_seg_type seg_q, seg_d;
  sscu_pkg::sscu_fsm_type fsm_q, fsm_d;
  logic wr_fire, cmd_we, cmd_ok, clr_we, en_we;
  logic [7:0] cmd;
  logic [31:0] wval;
  logic [15:0] seg_len;
  logic [sscu_pkg::EV_W-1:0] ev_set, ev_status, ev_enable;

  // Byte-lane merge of a write into an old register value
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] val, input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = val[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // ----------------------------------------
  // Submodules
  // ----------------------------------------
  sscu_seg_calc u_seg (
    .mode(mode_q),
    .mss(mss_q),
    .remaining(remaining_q),
    .seg_len(seg_len)
  );

  sscu_events u_events (
    .aclk(aclk),
    .aresetn(aresetn),
    .ev_set(ev_set),
    .clr_we(clr_we),
    .en_we(en_we),
    .wr_data(wval[sscu_pkg::EV_W-1:0]),
    .status(ev_status),
    .enable(ev_enable),
    .irq(irq)
  );

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    aw_have_d = aw_have_q;
    aw_addr_d = aw_addr_q;
    w_have_d = w_have_q;
    w_data_d = w_data_q;
    w_strb_d = w_strb_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    rvalid_d = rvalid_q;
    rresp_d = rresp_q;
    rdata_d = rdata_q;
    mode_d = mode_q;
    socket_state_d = socket_state_q;
    tx_wr_d = tx_wr_q;
    tx_rd_d = tx_rd_q;
    mss_d = mss_q;
    tx_free_space_d = tx_free_space_q;
    remaining_d = remaining_q;
    total_d = total_q;
    peer_d = peer_q;
    keep_d = keep_q;
    no_res_d = no_res_q;
    eng_req_d = eng_req_q;
    seg_d = seg_q;
    fsm_d = fsm_q;
    ev_set = '0;
    clr_we = 1'b0;
    en_we = 1'b0;
    cmd_we = 1'b0;
    cmd_ok = 1'b0;
    cmd = w_data_q[7:0];
    wval = w_data_q & {{8{w_strb_q[3]}}, {8{w_strb_q[2]}}, {8{w_strb_q[1]}}, {8{w_strb_q[0]}}};

    // Capture address and data separately, in either order
    if (s_axi_awvalid && awready_q) begin
      aw_have_d = 1'b1;
      aw_addr_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && wready_q) begin
      w_have_d = 1'b1;
      w_data_d = s_axi_wdata;
      w_strb_d = s_axi_wstrb;
    end

    // Perform a write once both halves are held
    wr_fire = aw_have_q && w_have_q && !bvalid_q;
    if (wr_fire) begin
      aw_have_d = 1'b0;
      w_have_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = sscu_pkg::RESP_OKAY;
      unique case ({aw_addr_q[7:2], 2'b00})
        sscu_pkg::REG_MODE: begin
          if (w_strb_q[0]) begin
            mode_d = (w_data_q[2:0] > sscu_pkg::MODE_RAW_FRAME) ? sscu_pkg::MODE_CLOSED : w_data_q[2:0];
            socket_state_d = (mode_d == sscu_pkg::MODE_CLOSED) ? sscu_pkg::CLOSED_STATE : sscu_pkg::OPEN_STATE;
          end
        end
        sscu_pkg::REG_CMD: cmd_we = w_strb_q[0];
        sscu_pkg::REG_TX_WR: tx_wr_d = 16'(merge({16'h0000, tx_wr_q}, w_data_q, w_strb_q));
        sscu_pkg::REG_MSS: mss_d = 16'(merge({16'h0000, mss_q}, w_data_q, w_strb_q));
        sscu_pkg::REG_EV_CLEAR: clr_we = 1'b1;
        sscu_pkg::REG_EV_ENABLE: en_we = 1'b1;
        sscu_pkg::REG_PEER_LO: peer_d[31:0] = merge(peer_q[31:0], w_data_q, w_strb_q);
        sscu_pkg::REG_PEER_HI: peer_d[47:32] = 16'(merge({16'h0000, peer_q[47:32]}, w_data_q, w_strb_q));
        sscu_pkg::REG_TX_RD, sscu_pkg::REG_FREE, sscu_pkg::REG_STATE, sscu_pkg::REG_EV_STATUS: ;
        default: bresp_d = sscu_pkg::RESP_SLVERR;
      endcase
    end
    if (bvalid_q && s_axi_bready) begin
      bvalid_d = 1'b0;
    end
    awready_d = !aw_have_d && !bvalid_d;
    wready_d = !w_have_d && !bvalid_d;

    // Read answer one cycle after the address is taken
    if (s_axi_arvalid && arready_q) begin
      rvalid_d = 1'b1;
      rresp_d = sscu_pkg::RESP_OKAY;
      rdata_d = 32'h0000_0000;
      unique case ({s_axi_araddr[7:2], 2'b00})
        sscu_pkg::REG_MODE: rdata_d[2:0] = mode_q;
        sscu_pkg::REG_TX_WR: rdata_d[15:0] = tx_wr_q;
        sscu_pkg::REG_TX_RD: rdata_d[15:0] = tx_rd_q;
        sscu_pkg::REG_MSS: rdata_d[15:0] = mss_q;
        sscu_pkg::REG_FREE: rdata_d[15:0] = tx_free_space_q;
        sscu_pkg::REG_STATE: rdata_d[7:0] = socket_state_q;
        sscu_pkg::REG_EV_STATUS: rdata_d[sscu_pkg::EV_W-1:0] = ev_status;
        sscu_pkg::REG_EV_ENABLE: rdata_d[sscu_pkg::EV_W-1:0] = ev_enable;
        sscu_pkg::REG_PEER_LO: rdata_d = peer_q[31:0];
        sscu_pkg::REG_PEER_HI: rdata_d[15:0] = peer_q[47:32];
        sscu_pkg::REG_CMD, sscu_pkg::REG_EV_CLEAR: ;
        default: rresp_d = sscu_pkg::RESP_SLVERR;
      endcase
    end
    if (rvalid_q && s_axi_rready) begin
      rvalid_d = 1'b0;
    end
    arready_d = !rvalid_d;

    // Check a command against the socket mode; others are dropped
    if (cmd_we && fsm_q == sscu_pkg::ST_IDLE && socket_state_q == sscu_pkg::OPEN_STATE) begin
      unique case (cmd)
        sscu_pkg::CMD_SEND: cmd_ok = 1'b1;
        sscu_pkg::CMD_SEND_NO_RESOLVE: cmd_ok = (mode_q == sscu_pkg::MODE_UDP) ||
                                                 (mode_q == sscu_pkg::MODE_RAW_IP);
        sscu_pkg::CMD_KEEPALIVE: cmd_ok = (mode_q == sscu_pkg::MODE_TCP);
        default: cmd_ok = 1'b0;
      endcase
    end

    // Send sequencer
    unique case (fsm_q)
      sscu_pkg::ST_IDLE: begin
        if (cmd_ok) begin
          keep_d = (cmd == sscu_pkg::CMD_KEEPALIVE);
          no_res_d = (cmd == sscu_pkg::CMD_SEND_NO_RESOLVE);
          remaining_d = keep_d ? 16'h0000 : 16'(tx_wr_q - tx_rd_q);
          total_d = remaining_d;
          tx_free_space_d = 16'(tx_free_space_q - remaining_d);
          fsm_d = (remaining_d == 16'h0000 && !keep_d) ? sscu_pkg::ST_DONE : sscu_pkg::ST_ISSUE;
        end
      end
      sscu_pkg::ST_ISSUE: begin
        eng_req_d = 1'b1;
        seg_d.addr = tx_rd_q;
        seg_d.len = seg_len;
        seg_d.no_resolve = no_res_q;
        seg_d.keepalive = keep_q;
        if (eng_req_q && eng_ready) begin
          eng_req_d = 1'b0;
          fsm_d = sscu_pkg::ST_WAIT_SENT;
        end
      end
      sscu_pkg::ST_WAIT_SENT: begin
        if (eng_evt.sent) begin
          tx_rd_d = 16'(tx_rd_q + seg_q.len);
          remaining_d = 16'(remaining_q - seg_q.len);
          if (remaining_d != 16'h0000) begin
            fsm_d = sscu_pkg::ST_ISSUE;
          end else if (keep_q) begin
            fsm_d = sscu_pkg::ST_IDLE;
          end else if (mode_q == sscu_pkg::MODE_TCP) begin
            fsm_d = sscu_pkg::ST_WAIT_ACK;
          end else begin
            fsm_d = sscu_pkg::ST_DONE;
          end
        end
      end
      sscu_pkg::ST_WAIT_ACK: begin
        if (eng_evt.acked) begin
          tx_free_space_d = 16'(tx_free_space_q + total_q);
          ev_set[sscu_pkg::EV_DONE] = 1'b1;
          fsm_d = sscu_pkg::ST_IDLE;
        end else if (eng_evt.timeout) begin
          ev_set[sscu_pkg::EV_TIMEOUT] = 1'b1;
          socket_state_d = sscu_pkg::CLOSED_STATE;
          fsm_d = sscu_pkg::ST_IDLE;
        end
      end
      sscu_pkg::ST_DONE: begin
        ev_set[sscu_pkg::EV_DONE] = 1'b1;
        fsm_d = sscu_pkg::ST_CREDIT;
      end
      sscu_pkg::ST_CREDIT: begin
        tx_free_space_d = 16'(tx_free_space_q + total_q);
        fsm_d = sscu_pkg::ST_IDLE;
      end
      default: fsm_d = sscu_pkg::ST_IDLE;
    endcase
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      aw_addr_q <= 8'h00;
      w_have_q <= 1'b0;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
      awready_q <= 1'b0;
      wready_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= sscu_pkg::RESP_OKAY;
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
      rresp_q <= sscu_pkg::RESP_OKAY;
      rdata_q <= 32'h0000_0000;
      mode_q <= sscu_pkg::MODE_CLOSED;
      socket_state_q <= sscu_pkg::CLOSED_STATE;
      tx_wr_q <= 16'h0000;
      tx_rd_q <= 16'h0000;
      mss_q <= sscu_pkg::MSS_RESET;
      tx_free_space_q <= sscu_pkg::TX_BUF_BYTES;
      remaining_q <= 16'h0000;
      total_q <= 16'h0000;
      peer_q <= 48'h0000_0000_0000;
      keep_q <= 1'b0;
      no_res_q <= 1'b0;
      eng_req_q <= 1'b0;
      seg_q <= '0;
      fsm_q <= sscu_pkg::ST_IDLE;
    end else begin
      aw_have_q <= aw_have_d;
      aw_addr_q <= aw_addr_d;
      w_have_q <= w_have_d;
      w_data_q <= w_data_d;
      w_strb_q <= w_strb_d;
      awready_q <= awready_d;
      wready_q <= wready_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      arready_q <= arready_d;
      rvalid_q <= rvalid_d;
      rresp_q <= rresp_d;
      rdata_q <= rdata_d;
      mode_q <= mode_d;
      socket_state_q <= socket_state_d;
      tx_wr_q <= tx_wr_d;
      tx_rd_q <= tx_rd_d;
      mss_q <= mss_d;
      tx_free_space_q <= tx_free_space_d;
      remaining_q <= remaining_d;
      total_q <= total_d;
      peer_q <= peer_d;
      keep_q <= keep_d;
      no_res_q <= no_res_d;
      eng_req_q <= eng_req_d;
      seg_q <= seg_d;
      fsm_q <= fsm_d;
    end
  end

  // Outputs straight from flops
  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rresp = rresp_q;
  assign s_axi_rdata = rdata_q;
  assign eng_req = eng_req_q;
  assign eng_seg = seg_q;
  assign peer_hw_address = peer_q;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  seg_limit_a: assert property (eng_req_q && mss_q != 16'h0000 && (mode_q == sscu_pkg::MODE_TCP ||
    mode_q == sscu_pkg::MODE_UDP) |-> seg_q.len <= mss_q) else $error("segment longer than segment size");
  raw_whole_a: assert property (fsm_q == sscu_pkg::ST_ISSUE && mode_q >= sscu_pkg::MODE_RAW_IP
    |=> seg_q.len == $past(remaining_q)) else $error("raw data was cut");
  tcp_credit_a: assert property (fsm_q == sscu_pkg::ST_WAIT_ACK && eng_evt.acked
    |=> tx_free_space_q == 16'($past(tx_free_space_q) + total_q) ##1 ev_status[sscu_pkg::EV_DONE])
    else $error("acknowledge did not credit free space");
  timeout_close_a: assert property (fsm_q == sscu_pkg::ST_WAIT_ACK && !eng_evt.acked && eng_evt.timeout
    |=> socket_state_q == sscu_pkg::CLOSED_STATE ##1 ev_status[sscu_pkg::EV_TIMEOUT])
    else $error("timeout did not close socket");
  done_then_add_a: assert property (fsm_q == sscu_pkg::ST_DONE |=> ev_status[sscu_pkg::EV_DONE] &&
    tx_free_space_q == $past(tx_free_space_q) ##1 tx_free_space_q == 16'($past(tx_free_space_q) + total_q))
    else $error("free space credited before done event");
  no_resolve_mode_a: assert property (eng_req_q && seg_q.no_resolve |-> mode_q == sscu_pkg::MODE_UDP ||
    mode_q == sscu_pkg::MODE_RAW_IP) else $error("no-resolve send in wrong mode");
  keep_send_a: assert property (cmd_ok && cmd == sscu_pkg::CMD_KEEPALIVE
    |-> mode_q == sscu_pkg::MODE_TCP ##2 eng_req_q && seg_q.keepalive)
    else $error("keep-alive not sent");
  send_size_a: assert property (cmd_ok && cmd != sscu_pkg::CMD_KEEPALIVE
    |=> remaining_q == 16'($past(tx_wr_q) - $past(tx_rd_q))) else $error("send size wrong");
  bad_cmd_a: assert property (cmd_we && fsm_q == sscu_pkg::ST_IDLE && !cmd_ok |=> fsm_q == sscu_pkg::ST_IDLE &&
    socket_state_q == $past(socket_state_q)) else $error("undefined command acted on");

endmodule

// ==== dv/sscu_eng_model.sv ====
/*
  Protocol engine and peer stand-in for the send unit bench.
  Assumes the unit's clock; each taken segment gets one sent pulse, then a peer answer when ack_mode is 1 or 2 and it is not a keep-alive.
*/
`timescale 1ns/1ps
module sscu_eng_model (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Segment link
  input wire logic eng_req,
  input wire sscu_pkg::sscu_seg_type eng_seg,
  output logic eng_ready,
  output sscu_pkg::sscu_eng_evt_type eng_evt,
  // Bench control: slow pacing; peer answer 0 none, 1 acknowledge, 2 timeout
  input wire logic slow,
  input wire logic [1:0] ack_mode,
  // Observed traffic
  output logic [7:0] n_seg,
  output sscu_pkg::sscu_seg_type last_seg
);
  logic [2:0] wait_q;
  logic [1:0] ackw_q;
  logic busy_q;
  logic ph_q;

  // Slow pacing offers ready only every other cycle
  assign eng_ready = !busy_q && (!slow || ph_q);

  // Take a segment, report it sent later, then answer as the peer
  always_ff @(posedge aclk) begin
    eng_evt <= '0;
    if (!aresetn) begin
      busy_q <= 1'h0;
      ackw_q <= 2'h0;
      ph_q <= 1'h0;
      n_seg <= 8'h0;
    end else begin
      ph_q <= !ph_q;
      if (eng_req && eng_ready) begin
        busy_q <= 1'h1;
        wait_q <= slow ? 3'h5 : 3'h0;
        n_seg <= n_seg + 8'h1;
        last_seg <= eng_seg;
      end else if (busy_q) begin
        wait_q <= wait_q - 3'h1;
        if (wait_q == 3'h0) begin
          busy_q <= 1'h0;
          eng_evt.sent <= 1'h1;
          ackw_q <= (ack_mode != 2'h0 && !last_seg.keepalive) ? 2'h2 : 2'h0;
        end
      end
      if (ackw_q != 2'h0) begin
        ackw_q <= ackw_q - 2'h1;
        eng_evt.acked <= (ackw_q == 2'h1) && (ack_mode == 2'h1);
        eng_evt.timeout <= (ackw_q == 2'h1) && (ack_mode == 2'h2);
      end
    end
  end
endmodule

// ==== dv/tb_top.sv ====
/*
  Self-checking bench of the socket send command unit.
  Assumes the engine model beside it and an AXI4-Lite master made of tasks.
*/
`timescale 1ns/1ps
`define CHK(n, e, g) begin n_checks++; if ((g) !== (e)) begin bad_count++; \
  $display("wrong value %s exp %h got %h", n, e, g); end end
module tb_top;
  typedef struct {logic [2:0] md; logic [7:0] cmd; logic [15:0] sz, mss; logic [1:0] ack;
    logic [7:0] segs; logic [15:0] len; logic [1:0] ev;} sscu_row_type;
  logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [7:0] awaddr = 0, araddr = 0, n_seg, n0;
  logic [31:0] wdata = 0, rdata, rv;
  logic awready, wready, bvalid, arready, rvalid, eng_req, eng_ready, irq, slow = 0;
  logic [1:0] bresp, rresp, rs, ack_mode = 0;
  logic [47:0] peer;
  logic [15:0] ptr = 0;
  sscu_pkg::sscu_seg_type eng_seg, last_seg;
  sscu_pkg::sscu_eng_evt_type eng_evt;
  int bad_count = 0, n_checks = 0, cyc = 0;
  sscu_row_type r;
  // Mode, command, size, segment size, peer answer, segments, last length, events
  sscu_row_type rows [12] = '{
    '{3'h2, 8'h20, 16'ha, 16'h100, 2'h0, 8'h1, 16'ha, 2'h1},
    '{3'h2, 8'h20, 16'h64, 16'h28, 2'h0, 8'h3, 16'h14, 2'h1},
    '{3'h1, 8'h20, 16'h64, 16'h28, 2'h1, 8'h3, 16'h14, 2'h1},
    '{3'h3, 8'h20, 16'h27, 16'h28, 2'h0, 8'h1, 16'h27, 2'h1},
    '{3'h4, 8'h20, 16'h27, 16'h28, 2'h0, 8'h1, 16'h27, 2'h1},
    '{3'h2, 8'h21, 16'h1e, 16'h100, 2'h0, 8'h1, 16'h1e, 2'h1},
    '{3'h3, 8'h21, 16'h1e, 16'h100, 2'h0, 8'h1, 16'h1e, 2'h1},
    '{3'h1, 8'h21, 16'h0, 16'h100, 2'h0, 8'h0, 16'h0, 2'h0},
    '{3'h4, 8'h21, 16'h0, 16'h100, 2'h0, 8'h0, 16'h0, 2'h0},
    '{3'h2, 8'h22, 16'h0, 16'h100, 2'h0, 8'h0, 16'h0, 2'h0},
    '{3'h1, 8'h22, 16'h0, 16'h100, 2'h0, 8'h1, 16'h0, 2'h0},
    '{3'h1, 8'h20, 16'h32, 16'h100, 2'h2, 8'h1, 16'h32, 2'h2}};

  sscu_top u_sscu_top (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .eng_req(eng_req),
    .eng_seg(eng_seg), .peer_hw_address(peer), .eng_ready(eng_ready), .eng_evt(eng_evt), .irq(irq));
  sscu_eng_model u_sscu_eng_model (.aclk(aclk), .aresetn(aresetn), .eng_req(eng_req), .eng_seg(eng_seg),
    .eng_ready(eng_ready), .eng_evt(eng_evt), .slow(slow), .ack_mode(ack_mode), .n_seg(n_seg),
    .last_seg(last_seg));

  // ----------------------------------------
  // Clock, hang limit and verdict
  // ----------------------------------------
  initial forever #2.5 aclk = ~aclk;
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 30000) begin
      bad_count++;
      summarize();
    end
  end
  task automatic summarize();
    if (bad_count == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // ----------------------------------------
  // Register bus master
  // ----------------------------------------
  // Address and data offered together, each released when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = sscu_pkg::RESP_OKAY);
    logic ad, dd;
    ad = 0;
    dd = 0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    while (!(ad && dd)) begin
      @(posedge aclk);
      if (awvalid && awready) ad = 1;
      if (wvalid && wready) dd = 1;
      if (ad) awvalid <= 0;
      if (dd) wvalid <= 0;
    end
    do @(posedge aclk); while (bvalid !== 1'b1);
    `CHK("bresp", er, bresp)
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] rr);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 0;
    end while (rvalid !== 1'b1);
    d = rdata;
    rr = rresp;
  endtask
  task automatic rchk(input string n, input logic [7:0] a, input logic [31:0] e);
    rd(a, rv, rs);
    `CHK(n, e, rv)
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1;
    @(posedge aclk);
    rchk("mss", sscu_pkg::REG_MSS, sscu_pkg::MSS_RESET);
    rchk("free", sscu_pkg::REG_FREE, sscu_pkg::TX_BUF_BYTES);
    rchk("state", sscu_pkg::REG_STATE, sscu_pkg::CLOSED_STATE);
    wr(sscu_pkg::REG_EV_ENABLE, 32'h3);
    // Peer address loaded before any send without resolution
    wr(sscu_pkg::REG_PEER_LO, 32'h1122_3344);
    wr(sscu_pkg::REG_PEER_HI, 32'h5566);
    `CHK("peer", 48'h5566_1122_3344, peer)
    // One command per row, each after the previous completed; TCP data precedes keep-alive
    for (int i = 0; i < 12; i++) begin
      r = rows[i];
      slow <= i[0];
      ack_mode <= r.ack;
      wr(sscu_pkg::REG_MODE, {29'h0, r.md});
      wr(sscu_pkg::REG_MSS, {16'h0, r.mss});
      wr(sscu_pkg::REG_EV_CLEAR, 32'h3);
      ptr = ptr + r.sz;
      wr(sscu_pkg::REG_TX_WR, {16'h0, ptr});
      n0 = n_seg;
      wr(sscu_pkg::REG_CMD, {24'h0, r.cmd});
      if (r.ev != 2'h0) for (int k = 0; k < 600 && irq !== 1'b1; k++) @(posedge aclk);
      else repeat (60) @(posedge aclk);
      `CHK("segs", r.segs, 8'(n_seg - n0))
      if (r.segs != 8'h0) begin
        `CHK("len", r.len, last_seg.len)
        `CHK("addr", 16'(ptr - r.len), last_seg.addr)
        `CHK("nores", r.cmd == 8'h21, last_seg.no_resolve)
        `CHK("keep", r.cmd == 8'h22, last_seg.keepalive)
      end
      rchk("status", sscu_pkg::REG_EV_STATUS, r.ev);
      rchk("free", sscu_pkg::REG_FREE, r.ack == 2'h2 ? 16'h7ce : 16'h800);
      rchk("state", sscu_pkg::REG_STATE, r.ack == 2'h2 ? 8'h0 : 8'h1);
      rchk("txrd", sscu_pkg::REG_TX_RD, ptr);
    end
    // Keep-alive on the socket closed by timeout is not sent
    n0 = n_seg;
    wr(sscu_pkg::REG_CMD, 32'h22);
    repeat (20) @(posedge aclk);
    `CHK("closed", n0, n_seg)
    rchk("status", sscu_pkg::REG_EV_STATUS, 32'h2);
    // Masked event, then unmask and clear
    wr(sscu_pkg::REG_MODE, 32'h2);
    wr(sscu_pkg::REG_EV_CLEAR, 32'h3);
    wr(sscu_pkg::REG_EV_ENABLE, 32'h2);
    ptr = ptr + 16'h4;
    wr(sscu_pkg::REG_TX_WR, {16'h0, ptr});
    wr(sscu_pkg::REG_CMD, 32'h20);
    repeat (60) @(posedge aclk);
    `CHK("irq", 1'b0, irq)
    rchk("status", sscu_pkg::REG_EV_STATUS, 32'h1);
    wr(sscu_pkg::REG_EV_ENABLE, 32'h3);
    repeat (2) @(posedge aclk);
    `CHK("irq", 1'b1, irq)
    wr(sscu_pkg::REG_EV_CLEAR, 32'h1);
    repeat (2) @(posedge aclk);
    `CHK("irq", 1'b0, irq)
    // Unmapped place and read-only write
    wr(8'h40, 32'h1, sscu_pkg::RESP_SLVERR);
    rd(8'h40, rv, rs);
    `CHK("rresp", sscu_pkg::RESP_SLVERR, rs)
    `CHK("rdata", 32'h0, rv)
    wr(sscu_pkg::REG_FREE, 32'h0);
    rchk("free", sscu_pkg::REG_FREE, 32'h7ce);
    // Reset in mid-run brings back the reset values
    aresetn <= 0;
    repeat (2) @(posedge aclk);
    aresetn <= 1;
    @(posedge aclk);
    rchk("free", sscu_pkg::REG_FREE, sscu_pkg::TX_BUF_BYTES);
    rchk("mss", sscu_pkg::REG_MSS, sscu_pkg::MSS_RESET);
    rchk("enable", sscu_pkg::REG_EV_ENABLE, 32'h0);
    summarize();
  end
endmodule
